// file: rtet_regs.sv
`timescale 1ns/1ps
`include "rtet_defines.svh"

module rtet_regs (
  input  wire logic                clk_i,
  input  wire logic                sys_rst_i,
  input  wire logic [11:0]         s_axi_awaddr_i,
  input  wire logic                s_axi_awvalid_i,
  output logic                     s_axi_awready_o,
  input  wire logic [31:0]         s_axi_wdata_i,
  input  wire logic [3:0]          s_axi_wstrb_i,
  input  wire logic                s_axi_wvalid_i,
  output logic                     s_axi_wready_o,
  output logic [1:0]               s_axi_bresp_o,
  output logic                     s_axi_bvalid_o,
  input  wire logic                s_axi_bready_i,
  input  wire logic [11:0]         s_axi_araddr_i,
  input  wire logic                s_axi_arvalid_i,
  output logic                     s_axi_arready_o,
  output logic [31:0]              s_axi_rdata_o,
  output logic [1:0]               s_axi_rresp_o,
  output logic                     s_axi_rvalid_o,
  input  wire logic                s_axi_rready_i,
  input  wire rtet_pkg::rtet_done_s done_i,
  output rtet_pkg::rtet_task_s     task_o,
  output rtet_pkg::rtet_nib_t      active_o,
  output logic                     irq_o
);

  logic                 awv_q;
  logic [11:0]          awa_q;
  logic                 wv_q;
  logic [31:0]          wd_q;
  logic [3:0]           ws_q;
  logic                 bv_q;
  logic [1:0]           br_q;
  logic                 rv_q;
  logic [31:0]          rd_q;
  logic [1:0]           rr_q;
  rtet_pkg::rtet_task_s task_q;
  rtet_pkg::rtet_task_s task_d;
  rtet_pkg::rtet_nib_t  act_q;
  rtet_pkg::rtet_nib_t  act_d;
  rtet_pkg::rtet_nib_t  sts_q;
  rtet_pkg::rtet_nib_t  sts_d;
  rtet_pkg::rtet_nib_t  en_q;
  rtet_pkg::rtet_nib_t  en_d;
  logic                 evt_q;
  logic                 evt_d;

  // Address and data are parked until both have arrived, in either order
  wire        aw_hs   = s_axi_awvalid_i && s_axi_awready_o;
  wire        w_hs    = s_axi_wvalid_i && s_axi_wready_o;
  wire        ar_hs   = s_axi_arvalid_i && s_axi_arready_o;
  wire        wr_fire = awv_q && wv_q && !bv_q;
  wire [11:0] wa      = {awa_q[11:2], 2'b00};
  wire [11:0] ra      = {s_axi_araddr_i[11:2], 2'b00};
  wire        lane0   = ws_q[0];
  wire        trig    = wr_fire && lane0 && wd_q[`RTET_TRIG_BIT];

  wire is_task = (wa <= `RTET_CCSTO);
  wire wr_evt  = wr_fire && lane0 && (wa == `RTET_EVT);
  wire wr_en   = wr_fire && lane0 && (wa == `RTET_EN);
  wire wr_clr  = wr_fire && lane0 && (wa == `RTET_CLR);
  wire wr_map  = is_task || (wa == `RTET_EVT) || (wa == `RTET_STS) ||
                 (wa == `RTET_EN) || (wa == `RTET_CLR) || (wa == `RTET_ACT);
  wire rd_map  = (ra <= `RTET_CCSTO) || (ra == `RTET_EVT) || (ra == `RTET_STS) ||
                 (ra == `RTET_EN) || (ra == `RTET_CLR) || (ra == `RTET_ACT);

  // Task words are write-only and never hold state; a write of 0 decodes to nothing
  assign task_d.tx_enable     = trig && (wa == `RTET_TXEN);
  assign task_d.rx_enable     = trig && (wa == `RTET_RXEN);
  assign task_d.radio_start   = trig && (wa == `RTET_START);
  assign task_d.radio_stop    = trig && (wa == `RTET_STOP);
  assign task_d.radio_disable = trig && (wa == `RTET_DIS);
  assign task_d.sl_start      = trig && (wa == `RTET_SLSTA);
  assign task_d.sl_stop       = trig && (wa == `RTET_SLSTO);
  assign task_d.bc_start      = trig && (wa == `RTET_BCSTA);
  assign task_d.bc_stop       = trig && (wa == `RTET_BCSTO);
  assign task_d.ed_start      = trig && (wa == `RTET_EDSTA);
  assign task_d.ed_stop       = trig && (wa == `RTET_EDSTO);
  assign task_d.assess_start  = trig && (wa == `RTET_CCSTA);
  assign task_d.assess_stop   = trig && (wa == `RTET_CCSTO);

  // Start beats stop or completion; a signal-level run ends after its one sample
  wire [3:0] act_set = {task_d.assess_start, task_d.ed_start, task_d.bc_start, task_d.sl_start};
  wire [3:0] act_clr = {task_d.assess_stop || done_i.assess_result,
                        task_d.ed_stop || done_i.ed_sample,
                        task_d.bc_stop,
                        task_d.sl_stop || done_i.sl_sample};
  assign act_d = (act_q & ~act_clr) | act_set;

  // Hardware set wins over a software clear landing in the same cycle
  wire [3:0] sts_set = {done_i.assess_result, done_i.ed_sample, done_i.sl_sample, done_i.ramp_up};
  wire [3:0] sts_clr = wr_clr ? wd_q[3:0] : `RTET_NIB_RST;
  assign sts_d = (sts_q & ~sts_clr) | sts_set;
  assign en_d  = wr_en ? wd_q[3:0] : en_q;
  assign evt_d = done_i.ramp_up ? 1'b1 : (wr_evt ? wd_q[`RTET_EVT_BIT] : evt_q);

  wire [31:0] rd_w = (ra == `RTET_EVT) ? {31'h0, evt_q} :
                     (ra == `RTET_STS) ? {28'h0, sts_q} :
                     (ra == `RTET_EN)  ? {28'h0, en_q}  :
                     (ra == `RTET_ACT) ? {28'h0, act_q} : 32'h0;

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      awv_q <= 1'b0;
      awa_q <= 12'h0;
    end else if (aw_hs) begin
      awv_q <= 1'b1;
      awa_q <= s_axi_awaddr_i;
    end else if (wr_fire) begin
      awv_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      wv_q <= 1'b0;
      wd_q <= 32'h0;
      ws_q <= 4'h0;
    end else if (w_hs) begin
      wv_q <= 1'b1;
      wd_q <= s_axi_wdata_i;
      ws_q <= s_axi_wstrb_i;
    end else if (wr_fire) begin
      wv_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      bv_q <= 1'b0;
      br_q <= `RTET_OKAY;
    end else if (wr_fire) begin
      bv_q <= 1'b1;
      br_q <= wr_map ? `RTET_OKAY : `RTET_SLVERR;
    end else if (s_axi_bready_i) begin
      bv_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rv_q <= 1'b0;
      rd_q <= 32'h0;
      rr_q <= `RTET_OKAY;
    end else if (ar_hs) begin
      rv_q <= 1'b1;
      rd_q <= rd_w;
      rr_q <= rd_map ? `RTET_OKAY : `RTET_SLVERR;
    end else if (s_axi_rready_i) begin
      rv_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      task_q <= '0;
      act_q  <= `RTET_NIB_RST;
      sts_q  <= `RTET_NIB_RST;
      en_q   <= `RTET_NIB_RST;
      evt_q  <= `RTET_EVT_RST;
    end else begin
      task_q <= task_d;
      act_q  <= act_d;
      sts_q  <= sts_d;
      en_q   <= en_d;
      evt_q  <= evt_d;
    end
  end

  // A second address may park while the response waits, but cannot fire
  assign s_axi_awready_o = !awv_q;
  assign s_axi_wready_o  = !wv_q;
  assign s_axi_bvalid_o  = bv_q;
  assign s_axi_bresp_o   = br_q;
  assign s_axi_arready_o = !rv_q;
  assign s_axi_rvalid_o  = rv_q;
  assign s_axi_rdata_o   = rd_q;
  assign s_axi_rresp_o   = rr_q;
  assign task_o          = task_q;
  assign active_o        = act_q;
  assign irq_o           = |(sts_q & en_q);

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  sequence s_wr_at(logic [11:0] off);
    trig && (wa == off);
  endsequence

  // A run counts as busy only when no fresh start could mask the end of its sample
  sequence s_sl_busy;
    act_q[`RTET_A_SL] && !task_d.sl_start;
  endsequence

  sequence s_sl_sampled;
    done_i.sl_sample;
  endsequence

  chk_rx_task_pulse:
  assert property (s_wr_at(`RTET_RXEN) |=> task_o.rx_enable && s_axi_bvalid_o && !task_o.tx_enable)
    else $error("receive enable task did not pulse");

  chk_tx_task_pulse:
  assert property (s_wr_at(`RTET_TXEN) |=> task_o.tx_enable && !task_o.rx_enable)
    else $error("transmit enable task did not pulse");

  chk_sl_one_sample:
  assert property (s_sl_busy ##0 s_sl_sampled |=> !active_o[`RTET_A_SL])
    else $error("signal level run did not end after its sample");

  chk_sl_start_act:
  assert property (s_wr_at(`RTET_SLSTA) |=> task_o.sl_start && active_o[`RTET_A_SL])
    else $error("signal level start did not activate");

  chk_sl_stop_halt:
  assert property (s_wr_at(`RTET_SLSTO) |=> !active_o[`RTET_A_SL] && task_o.sl_stop)
    else $error("signal level stop did not halt");

  chk_bc_start_run:
  assert property (s_wr_at(`RTET_BCSTA) |=> active_o[`RTET_B_BC] ##1 active_o[`RTET_B_BC])
    else $error("bit counter did not start");

  chk_bc_stop_hold:
  assert property (task_o.bc_stop |-> !active_o[`RTET_B_BC] ##1 !active_o[`RTET_B_BC])
    else $error("bit counter kept running after stop");

  chk_ed_start_act:
  assert property (s_wr_at(`RTET_EDSTA) |=> active_o[`RTET_B_ED] && task_o.ed_start)
    else $error("energy detect did not start");

  chk_ed_stop_end:
  assert property (task_o.ed_stop |-> !active_o[`RTET_B_ED])
    else $error("energy detect not ended by stop");

  chk_assess_start_act:
  assert property (s_wr_at(`RTET_CCSTA) |=> active_o[`RTET_B_ASSESS] && task_o.assess_start)
    else $error("channel assessment did not start");

  chk_assess_stop_end:
  assert property (task_o.assess_stop |-> !active_o[`RTET_B_ASSESS] ##1
                   (!active_o[`RTET_B_ASSESS] || task_o.assess_start))
    else $error("channel assessment not aborted");

  chk_ramp_evt_set:
  assert property (done_i.ramp_up |=> evt_q && sts_q[`RTET_B_RAMP])
    else $error("ramp-up event not recorded");

  chk_zero_no_task:
  assert property (wr_fire && !trig |=> task_o == '0)
    else $error("write of zero fired a task");

  chk_start_one_pulse:
  assert property (s_wr_at(`RTET_START) |=> task_o.radio_start ##1 !task_o.radio_start)
    else $error("start task pulse not single cycle");

  chk_irq_follows:
  assert property (done_i.ramp_up && en_q[`RTET_B_RAMP] && !wr_en |=> irq_o)
    else $error("interrupt did not follow an enabled event");

  chk_wr_resp_next:
  assert property (wr_fire |=> s_axi_bvalid_o)
    else $error("write response did not follow the write");

  chk_rd_resp_next:
  assert property (ar_hs |=> s_axi_rvalid_o)
    else $error("read response did not follow the address");

  chk_wr_okay_mapped:
  assert property (wr_fire && wr_map |=> s_axi_bresp_o == `RTET_OKAY)
    else $error("mapped write not answered okay");

  chk_wr_slverr_unmapped:
  assert property (wr_fire && !wr_map |=> s_axi_bresp_o == `RTET_SLVERR)
    else $error("unmapped write not refused");

  chk_rd_slverr_unmapped:
  assert property (ar_hs && !rd_map |=> s_axi_rresp_o == `RTET_SLVERR && s_axi_rdata_o == 32'h0)
    else $error("unmapped read not refused");

  chk_task_reads_zero:
  assert property (ar_hs && (ra <= `RTET_CCSTO) |=> s_axi_rdata_o == 32'h0 && s_axi_rresp_o == `RTET_OKAY)
    else $error("task word did not read as zero");

  chk_evt_read_back:
  assert property (ar_hs && (ra == `RTET_EVT) |=> s_axi_rdata_o[`RTET_EVT_BIT] == $past(evt_q))
    else $error("event word read back wrong value");

  chk_evt_sw_clear:
  assert property (wr_evt && !wd_q[`RTET_EVT_BIT] && !done_i.ramp_up |=> !evt_q)
    else $error("event not cleared by a write of zero");

  chk_evt_sticky:
  assert property (evt_q && !wr_evt |=> evt_q)
    else $error("event dropped without a write");

  chk_task_single_cycle:
  assert property (task_o != '0 |=> task_o == '0)
    else $error("task pulse lasted more than one cycle");

  chk_sts_sticky:
  assert property (sts_q[`RTET_B_RAMP] && !(wr_clr && wd_q[`RTET_B_RAMP]) |=> sts_q[`RTET_B_RAMP])
    else $error("status bit dropped without a clear");

  chk_clr_drops_irq:
  assert property (wr_clr && ((sts_q & ~wd_q[3:0]) == 4'h0) && (done_i == '0) |=> !irq_o)
    else $error("interrupt stayed high after clearing all status");

  chk_en_written:
  assert property (wr_en |=> en_q == $past(wd_q[3:0]))
    else $error("enable word not written");

  chk_bc_keeps_count:
  assert property (active_o[`RTET_B_BC] && !task_d.bc_stop |=> active_o[`RTET_B_BC])
    else $error("bit counter stopped without a stop task");

  chk_ed_one_result:
  assert property (act_q[`RTET_B_ED] && done_i.ed_sample && !task_d.ed_start |=> !active_o[`RTET_B_ED])
    else $error("energy detect still active after its result");

  chk_assess_result_end:
  assert property (act_q[`RTET_B_ASSESS] && done_i.assess_result && !task_d.assess_start
                   |=> !active_o[`RTET_B_ASSESS])
    else $error("channel assessment still active after its result");

  chk_radio_stop_pulse:
  assert property (s_wr_at(`RTET_STOP) |=> task_o.radio_stop)
    else $error("stop task did not pulse");

  chk_disable_pulse:
  assert property (s_wr_at(`RTET_DIS) |=> task_o.radio_disable)
    else $error("disable task did not pulse");

  chk_bc_stop_pulse:
  assert property (s_wr_at(`RTET_BCSTO) |=> task_o.bc_stop && !active_o[`RTET_B_BC])
    else $error("bit counter stop did not pulse");

endmodule

// file: rtet_defines.svh
`ifndef RTET_DEFINES_SVH
`define RTET_DEFINES_SVH

// Byte offsets of the register words
`define RTET_TXEN     12'h000
`define RTET_RXEN     12'h004
`define RTET_START    12'h008
`define RTET_STOP     12'h00c
`define RTET_DIS      12'h010
`define RTET_SLSTA    12'h014
`define RTET_SLSTO    12'h018
`define RTET_BCSTA    12'h01c
`define RTET_BCSTO    12'h020
`define RTET_EDSTA    12'h024
`define RTET_EDSTO    12'h028
`define RTET_CCSTA    12'h02c
`define RTET_CCSTO    12'h030
`define RTET_EVT      12'h100
`define RTET_STS      12'h380
`define RTET_EN       12'h384
`define RTET_CLR      12'h388
`define RTET_ACT      12'h38c

// Field positions
`define RTET_TRIG_BIT 0
`define RTET_EVT_BIT  0
`define RTET_B_RAMP   0
`define RTET_B_SL     1
`define RTET_B_ED     2
`define RTET_B_ASSESS 3
// Activity keeps a signal-level run in bit 0, where status keeps ramp-up
`define RTET_A_SL     0
`define RTET_B_BC     1

// Reset values
`define RTET_EVT_RST  1'b0
`define RTET_NIB_RST  4'h0

// Response codes
`define RTET_OKAY     2'h0
`define RTET_SLVERR   2'h2

`endif

// file: rtet_pkg.sv
package rtet_pkg;

  typedef struct packed {
    logic tx_enable;
    logic rx_enable;
    logic radio_start;
    logic radio_stop;
    logic radio_disable;
    logic sl_start;
    logic sl_stop;
    logic bc_start;
    logic bc_stop;
    logic ed_start;
    logic ed_stop;
    logic assess_start;
    logic assess_stop;
  } rtet_task_s;

  typedef struct packed {
    logic ramp_up;
    logic sl_sample;
    logic ed_sample;
    logic assess_result;
  } rtet_done_s;

  typedef logic [3:0] rtet_nib_t;

endpackage

// file: rtet_radio_model.sv
`timescale 1ns/1ps
module rtet_radio_model #(
  parameter int DLY = 3
) (
  input  wire logic                 clk_i,
  input  wire logic                 sys_rst_i,
  input  wire rtet_pkg::rtet_task_s task_i,
  output rtet_pkg::rtet_done_s      done_o
);
  // Each enable and each signal-level, energy-detect or assessment start answers with a one-cycle pulse DLY cycles after its trigger; stops do not cancel it,
  // so an answer could land after a stop as a real core might deliver it, though with DLY of 3 every answer here comes before its stop
  logic [4*DLY-1:0] pipe_q;
  logic [3:0]       req;
  assign req    = {task_i.rx_enable | task_i.tx_enable, task_i.sl_start, task_i.ed_start, task_i.assess_start};
  assign done_o = pipe_q[4*DLY-1 -: 4];
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pipe_q <= '0;
    end else begin
      pipe_q <= {pipe_q[4*DLY-5:0], req};
    end
  end
endmodule

// file: testbench.sv
`timescale 1ns/1ps
`include "rtet_defines.svh"
module testbench;
  localparam int DLY = 3;
  logic                 clk_i, sys_rst_i, awvalid, wvalid, bready, arvalid, rready;
  logic [11:0]          awaddr, araddr;
  logic [31:0]          wdata, rdata;
  logic [3:0]           wstrb;
  logic                 awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0]           bresp, rresp;
  rtet_pkg::rtet_task_s task_o;
  rtet_pkg::rtet_done_s done;
  rtet_pkg::rtet_nib_t  active;
  logic [12:0]          q_task[$];
  logic [1:0]           q_resp[$];
  logic [33:0]          q_rd[$];
  int                   fails, n_checks, cyc, seed;

  rtet_regs i_rtet_regs (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .s_axi_awaddr_i(awaddr),
    .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb),
    .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
    .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
    .s_axi_rready_i(rready), .done_i(done), .task_o(task_o), .active_o(active), .irq_o(irq));
  rtet_radio_model #(.DLY(DLY)) i_rtet_radio_model (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .task_i(task_o), .done_o(done));

  task automatic cmp(input logic [33:0] got, input logic [33:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic cmp_task(input logic [12:0] g, input logic [12:0] e); cmp(g, e, "task pulse"); endtask
  task automatic cmp_resp(input logic [1:0] g, input logic [1:0] e); cmp(g, e, "write response"); endtask
  task automatic cmp_rd(input logic [33:0] g, input logic [33:0] e); cmp(g, e, "read response"); endtask
  task automatic cmp_lvl(input logic [3:0] g, input logic [3:0] e); cmp(g, e, "level output"); endtask

  task print_verdict;
    if (fails == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // Both channels offered together; each released at the edge that takes it
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    q_resp.push_back(er);
    awaddr  <= a;
    awvalid <= 1'b1;
    wdata   <= d;
    wvalid  <= 1'b1;
    forever begin
      @(posedge clk_i);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid && bready) break;
    end
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    q_rd.push_back({er, d});
    araddr  <= a;
    arvalid <= 1'b1;
    forever begin
      @(posedge clk_i);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
  endtask
  task automatic check_active(input logic [3:0] e);
    #1 cmp_lvl(active, e);
    @(posedge clk_i);
  endtask
  task automatic check_irq(input logic e);
    #1 cmp_lvl({3'h0, irq}, {3'h0, e});
    @(posedge clk_i);
  endtask

  always @(posedge clk_i) begin
    if (task_o !== '0) cmp_task(task_o, q_task.size() ? q_task.pop_front() : 13'h0);
    if (bvalid && bready) cmp_resp(bresp, q_resp.size() ? q_resp.pop_front() : 2'h3);
    if (rvalid && rready) cmp_rd({rresp, rdata}, q_rd.size() ? q_rd.pop_front() : 34'h3_ffff_ffff);
  end

  // Whole run is under two hundred cycles; the ceiling only cuts a stuck handshake short
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      fails++;
      print_verdict();
    end
  end

  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  initial begin
    {awvalid, wvalid, arvalid, awaddr, araddr, wdata} = '0;
    bready    = 1'b1;
    rready    = 1'b1;
    wstrb     = 4'hf;
    seed      = 95;
    sys_rst_i = 1'b1;
    repeat (3) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    for (int i = 0; i < 13; i++) begin
      wr(12'(i * 4), $random(seed) & 32'hffff_fffe, `RTET_OKAY);
      q_task.push_back(13'h1000 >> i);
      wr(12'(i * 4), $random(seed) | 32'h1, `RTET_OKAY);
    end
    for (int k = 0; k < 4; k++) begin
      q_task.push_back(13'h0080 >> (2 * k));
      wr(12'(20 + 8 * k), 32'h1, `RTET_OKAY);
      check_active(4'h1 << k);
      q_task.push_back(13'h0040 >> (2 * k));
      wr(12'(24 + 8 * k), 32'h1, `RTET_OKAY);
      check_active(4'h0);
    end
    q_task.push_back(13'h0020);
    wr(12'h01c, 32'h1, `RTET_OKAY);
    rd(12'h38c, 32'h2, `RTET_OKAY);
    q_task.push_back(13'h0010);
    wr(12'h020, 32'h1, `RTET_OKAY);
    rd(12'h38c, 32'h0, `RTET_OKAY);
    wstrb <= 4'he;
    wr(12'h008, 32'h1, `RTET_OKAY);
    wstrb <= 4'hf;
    wr(12'h200, 32'h1, `RTET_SLVERR);
    wr(12'h388, 32'hf, `RTET_OKAY);
    wr(12'h100, 32'h0, `RTET_OKAY);
    wr(12'h384, 32'h1, `RTET_OKAY);
    check_irq(1'b0);
    q_task.push_back(13'h0800);
    wr(12'h004, 32'h1, `RTET_OKAY);
    repeat (DLY + 1) @(posedge clk_i);
    check_irq(1'b1);
    rd(12'h380, 32'h1, `RTET_OKAY);
    wr(12'h384, 32'h0, `RTET_OKAY);
    check_irq(1'b0);
    wr(12'h384, 32'h1, `RTET_OKAY);
    check_irq(1'b1);
    rd(12'h384, 32'h1, `RTET_OKAY);
    wr(12'h388, 32'h1, `RTET_OKAY);
    check_irq(1'b0);
    rd(12'h100, 32'h1, `RTET_OKAY);
    wr(12'h100, 32'h0, `RTET_OKAY);
    rd(12'h100, 32'h0, `RTET_OKAY);
    rd(12'h004, 32'h0, `RTET_OKAY);
    rd(12'h01c, 32'h0, `RTET_OKAY);
    rd(12'h200, 32'h0, `RTET_SLVERR);
    repeat (4) @(posedge clk_i);
    cmp_lvl(4'(q_task.size() + q_resp.size() + q_rd.size()), 4'h0);
    print_verdict();
  end
endmodule
